// File: axis_feedback_pin_routing.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps

// What this block does
// RQ1: A set step-output enable bit drives pulse and direction onto the T/U/V/W flag lines.
// RQ2: The step-output enable bits clear at every reset; the host must write them again.
// RQ3: Strap one on puts channel 0 amplifier enable on its encoder A lines, else A is input.
// RQ4: Strap two on puts channel 1 amplifier enable on its encoder A lines, else A is input.
// RQ5: Strap three on takes channel 0 amplifier fault from encoder B, else not from B.
// RQ6: Strap four on takes channel 1 amplifier fault from encoder B, else not from B.
// RQ7: All four drive straps default off, leaving encoder A and B as plain inputs.
// RQ8: Share strap A default with channel 0 serial enable set turns index lines to outputs.
// RQ9: Share strap B default with channel 1 serial enable set turns index lines to outputs.
// RQ10: A share strap in its alternate position keeps that channel's index lines as inputs.
// RQ11: Boards without share straps act as in the default strap position.
// RQ12: Channel 0 is hardware channel 1 or 3, channel 1 is 2 or 4, by board position.
// RQ13: A cleared serial enable keeps that channel's index lines as inputs.
module axis_feedback_pin_routing #(
   parameter int unsigned CHANNELS = pin_routing_pkg::NUM_CHANNELS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Board straps, 1 = on or pins 2-3 for the share straps
   input wire logic [CHANNELS-1:0] amp_enable_route_strap,
   input wire logic [CHANNELS-1:0] amp_fault_route_strap,
   input wire logic [CHANNELS-1:0] index_share_strap,
   input wire logic legacy_board,
   input wire logic piggyback_board,
   // Core side per channel
   input wire logic [CHANNELS-1:0] amp_enable,
   input wire logic [CHANNELS-1:0] amp_fault_conn,
   input wire logic [CHANNELS-1:0] step_pulse,
   input wire logic [CHANNELS-1:0] step_dir,
   input wire logic [CHANNELS-1:0] serial_encoder_strobe,
   output logic [CHANNELS-1:0] enc_a_core,
   output logic [CHANNELS-1:0] enc_b_core,
   output logic [CHANNELS-1:0] enc_index_core,
   output logic [CHANNELS-1:0] amp_fault_state,
   // Connector side per channel
   input wire logic [CHANNELS-1:0] enc_a_in,
   input wire logic [CHANNELS-1:0] enc_b_in,
   input wire logic [CHANNELS-1:0] enc_index_in,
   output logic [CHANNELS-1:0] enc_a_out,
   output logic [CHANNELS-1:0] enc_a_oe_b,
   output logic [4*CHANNELS-1:0] flag_tuvw_out,
   output logic [CHANNELS-1:0] flag_tuvw_oe_b,
   output logic [CHANNELS-1:0] serial_encoder_strobe_out,
   output logic [CHANNELS-1:0] index_oe_b,
   // Hardware channel number of channel 0
   output logic [2:0] first_hw_channel
);

   // Field spacing in the package leaves room for four channels
   if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_channels
      $error("CHANNELS must be 1 to 4");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [CHANNELS-1:0] step_output_enable;
   logic [CHANNELS-1:0] serial_encoder_enable;
   logic [31:0] ctrl_word;
   logic [31:0] strap_word;
   logic [31:0] status_word;
   logic [31:0] board_word;
   logic [31:0] next_prdata;
   logic access;
   logic wr_ctrl;
   logic [7:0] ctrl_low;
   logic known_addr;

   assign access = psel & penable & ~pready;
   // Write commits at the edge where the master sees pready
   assign wr_ctrl = psel & penable & pready & pwrite &
      (paddr == pin_routing_pkg::CTRL_OFFSET);
   assign known_addr = (paddr == pin_routing_pkg::CTRL_OFFSET) |
      (paddr == pin_routing_pkg::STRAP_OFFSET) |
      (paddr == pin_routing_pkg::STATUS_OFFSET) |
      (paddr == pin_routing_pkg::BOARD_OFFSET);
   // Only byte lane 0 holds writable bits
   assign ctrl_low = pstrb[0] ? pwdata[7:0] : ctrl_word[7:0];

   // Control bits volatile: reset always clears them
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         step_output_enable <= '0; // [RQ2]
         serial_encoder_enable <= '0;
      end else if (wr_ctrl) begin
         step_output_enable <=
            ctrl_low[pin_routing_pkg::CTRL_STEP_POS +: CHANNELS]; // [RQ1]
         serial_encoder_enable <= ctrl_low[pin_routing_pkg::CTRL_SENC_POS +: CHANNELS];
      end
   end

   always_comb begin
      ctrl_word = pin_routing_pkg::CTRL_RESET;
      strap_word = 32'h0000_0000;
      status_word = 32'h0000_0000;
      board_word = 32'h0000_0000;
      ctrl_word[pin_routing_pkg::CTRL_STEP_POS +: CHANNELS] = step_output_enable;
      ctrl_word[pin_routing_pkg::CTRL_SENC_POS +: CHANNELS] = serial_encoder_enable;
      strap_word[pin_routing_pkg::STRAP_ENA_POS +: CHANNELS] = amp_enable_route_strap;
      strap_word[pin_routing_pkg::STRAP_FLT_POS +: CHANNELS] = amp_fault_route_strap;
      strap_word[pin_routing_pkg::STRAP_IDX_POS +: CHANNELS] = index_share_strap;
      strap_word[pin_routing_pkg::STRAP_LEGACY_POS] = legacy_board;
      status_word[pin_routing_pkg::STAT_FAULT_POS +: CHANNELS] = amp_fault_state;
      status_word[pin_routing_pkg::STAT_ENCA_POS +: CHANNELS] = ~enc_a_oe_b;
      status_word[pin_routing_pkg::STAT_STEP_POS +: CHANNELS] = ~flag_tuvw_oe_b;
      status_word[pin_routing_pkg::STAT_SENC_POS +: CHANNELS] = ~index_oe_b;
      board_word[pin_routing_pkg::BOARD_POS +: 3] = first_hw_channel;
      case (paddr)
         pin_routing_pkg::CTRL_OFFSET: next_prdata = ctrl_word;
         pin_routing_pkg::STRAP_OFFSET: next_prdata = strap_word;
         pin_routing_pkg::STATUS_OFFSET: next_prdata = status_word;
         pin_routing_pkg::BOARD_OFFSET: next_prdata = board_word;
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   // One wait state: pready pulses in the second access cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access & ~known_addr;
         if (access && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         first_hw_channel <= pin_routing_pkg::HW_CHAN_BASE;
      end else begin
         first_hw_channel <= piggyback_board ?
            pin_routing_pkg::HW_CHAN_PIGGY : pin_routing_pkg::HW_CHAN_BASE; // [RQ12]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channels; straps read as 0 when unfitted, giving the off default [RQ7]

   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      channel_route u_route (
         .mclk(mclk),
         .rst_b(rst_b),
         .step_output_enable(step_output_enable[ch]),
         .serial_encoder_enable(serial_encoder_enable[ch]),
         .amp_enable_route_strap(amp_enable_route_strap[ch]),
         .amp_fault_route_strap(amp_fault_route_strap[ch]),
         .index_share_strap(index_share_strap[ch]),
         .legacy_board(legacy_board),
         .amp_enable(amp_enable[ch]),
         .amp_fault_conn(amp_fault_conn[ch]),
         .step_pulse(step_pulse[ch]),
         .step_dir(step_dir[ch]),
         .serial_encoder_strobe(serial_encoder_strobe[ch]),
         .enc_a_core(enc_a_core[ch]),
         .enc_b_core(enc_b_core[ch]),
         .enc_index_core(enc_index_core[ch]),
         .amp_fault_state(amp_fault_state[ch]),
         .enc_a_in(enc_a_in[ch]),
         .enc_b_in(enc_b_in[ch]),
         .enc_index_in(enc_index_in[ch]),
         .enc_a_out(enc_a_out[ch]),
         .enc_a_oe_b(enc_a_oe_b[ch]),
         .flag_tuvw_out(flag_tuvw_out[4*ch +: 4]),
         .flag_tuvw_oe_b(flag_tuvw_oe_b[ch]),
         .serial_encoder_strobe_out(serial_encoder_strobe_out[ch]),
         .index_oe_b(index_oe_b[ch])
      );
   end

endmodule

// File: pin_routing_pkg.sv
package pin_routing_pkg;

   // Channel count per board
   localparam int unsigned NUM_CHANNELS = 2;

   // APB register byte offsets
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] STRAP_OFFSET = 12'h004;
   localparam logic [11:0] STATUS_OFFSET = 12'h008;
   localparam logic [11:0] BOARD_OFFSET = 12'h00C;

   // Control register fields, bit position of channel 0; channel n adds n
   localparam int unsigned CTRL_STEP_POS = 0;
   localparam int unsigned CTRL_SENC_POS = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Strap register fields, channel 0 positions
   localparam int unsigned STRAP_ENA_POS = 0;
   localparam int unsigned STRAP_FLT_POS = 4;
   localparam int unsigned STRAP_IDX_POS = 8;
   localparam int unsigned STRAP_LEGACY_POS = 12;

   // Status register fields, channel 0 positions
   localparam int unsigned STAT_FAULT_POS = 0;
   localparam int unsigned STAT_ENCA_POS = 4;
   localparam int unsigned STAT_STEP_POS = 8;
   localparam int unsigned STAT_SENC_POS = 12;

   // Board position field
   localparam int unsigned BOARD_POS = 0;

   // Hardware channel numbers of first channel on base and piggyback boards
   localparam logic [2:0] HW_CHAN_BASE = 3'h1;
   localparam logic [2:0] HW_CHAN_PIGGY = 3'h3;

endpackage

// File: channel_route.sv
`timescale 1ns/100ps

// Per-channel pin routing, all outputs registered
module channel_route (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Configuration
   input wire logic step_output_enable,
   input wire logic serial_encoder_enable,
   input wire logic amp_enable_route_strap,
   input wire logic amp_fault_route_strap,
   input wire logic index_share_strap,
   input wire logic legacy_board,
   // Core side
   input wire logic amp_enable,
   input wire logic amp_fault_conn,
   input wire logic step_pulse,
   input wire logic step_dir,
   input wire logic serial_encoder_strobe,
   output logic enc_a_core,
   output logic enc_b_core,
   output logic enc_index_core,
   output logic amp_fault_state,
   // Connector side
   input wire logic enc_a_in,
   input wire logic enc_b_in,
   input wire logic enc_index_in,
   output logic enc_a_out,
   output logic enc_a_oe_b,
   output logic [3:0] flag_tuvw_out,
   output logic flag_tuvw_oe_b,
   output logic serial_encoder_strobe_out,
   output logic index_oe_b
);

   logic index_is_output;

   // Old boards lack the share strap and act as in its default position
   assign index_is_output = serial_encoder_enable &
      (legacy_board | ~index_share_strap); // [RQ8] [RQ9] [RQ10] [RQ11] [RQ13]

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         enc_a_out <= 1'b0;
         enc_a_oe_b <= 1'b1;
         enc_a_core <= 1'b0;
      end else begin
         enc_a_out <= amp_enable_route_strap ? amp_enable : 1'b0; // [RQ3] [RQ4]
         enc_a_oe_b <= ~amp_enable_route_strap; // [RQ3] [RQ4]
         enc_a_core <= amp_enable_route_strap ? 1'b0 : enc_a_in;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         amp_fault_state <= 1'b0;
         enc_b_core <= 1'b0;
      end else begin
         // Fault from encoder B only when routed; else from amplifier board
         amp_fault_state <= amp_fault_route_strap ? enc_b_in : amp_fault_conn; // [RQ5] [RQ6]
         enc_b_core <= amp_fault_route_strap ? 1'b0 : enc_b_in;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flag_tuvw_out <= 4'h0;
         flag_tuvw_oe_b <= 1'b1;
      end else begin
         // T and U carry pulse, V and W carry direction
         flag_tuvw_out <= step_output_enable ?
            {step_dir, step_dir, step_pulse, step_pulse} : 4'h0; // [RQ1]
         flag_tuvw_oe_b <= ~step_output_enable; // [RQ1]
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         serial_encoder_strobe_out <= 1'b0;
         index_oe_b <= 1'b1;
         enc_index_core <= 1'b0;
      end else begin
         serial_encoder_strobe_out <= index_is_output ? serial_encoder_strobe : 1'b0; // [RQ8] [RQ9]
         index_oe_b <= ~index_is_output; // [RQ10] [RQ13]
         enc_index_core <= index_is_output ? 1'b0 : enc_index_in; // [RQ10] [RQ13]
      end
   end

endmodule

// File: axis_feedback_pin_routing_assertions.sv
`timescale 1ns/100ps
module axis_feedback_pin_routing_checker #(
   parameter int unsigned CHANNELS = 2
) (
   // Clock, reset and bus
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Straps and inputs
   input wire logic [CHANNELS-1:0] amp_enable_route_strap,
   input wire logic [CHANNELS-1:0] amp_fault_route_strap,
   input wire logic piggyback_board,
   input wire logic [CHANNELS-1:0] amp_enable,
   input wire logic [CHANNELS-1:0] amp_fault_conn,
   input wire logic [CHANNELS-1:0] step_pulse,
   input wire logic [CHANNELS-1:0] step_dir,
   input wire logic [CHANNELS-1:0] serial_encoder_strobe,
   input wire logic [CHANNELS-1:0] enc_b_in,
   // Routed outputs
   input wire logic [CHANNELS-1:0] amp_fault_state,
   input wire logic [CHANNELS-1:0] enc_a_out,
   input wire logic [CHANNELS-1:0] enc_a_oe_b,
   input wire logic [4*CHANNELS-1:0] flag_tuvw_out,
   input wire logic [CHANNELS-1:0] flag_tuvw_oe_b,
   input wire logic [CHANNELS-1:0] serial_encoder_strobe_out,
   input wire logic [CHANNELS-1:0] index_oe_b,
   input wire logic [2:0] first_hw_channel
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   a_apb_answer: assert property (s_setup |=> pready)
      else $error("access phase not answered after one wait state");
   a_unmapped_err: assert property (pready && paddr > pin_routing_pkg::BOARD_OFFSET |-> pslverr)
      else $error("unmapped access answered without error");
   a_reset_clear: assert property ($rose(rst_b) |=> &flag_tuvw_oe_b && &index_oe_b)
      else $error("lines driven just after reset");
   a_hw_channel: assert property ($past(rst_b) |-> first_hw_channel ==
      ($past(piggyback_board) ? pin_routing_pkg::HW_CHAN_PIGGY : pin_routing_pkg::HW_CHAN_BASE))
      else $error("wrong hardware channel number");
   for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      a_amp_enable: assert property ($past(rst_b) |->
         enc_a_oe_b[i] == !$past(amp_enable_route_strap[i]) &&
         enc_a_out[i] == ($past(amp_enable[i]) && $past(amp_enable_route_strap[i])))
         else $error("amplifier enable routing wrong");
      a_fault_source: assert property ($past(rst_b) |-> amp_fault_state[i] ==
         ($past(amp_fault_route_strap[i]) ? $past(enc_b_in[i]) : $past(amp_fault_conn[i])))
         else $error("amplifier fault source wrong");
      a_step_drive: assert property ($past(rst_b) |-> flag_tuvw_out[4*i+:4] ==
         (flag_tuvw_oe_b[i] ? 4'h0 : {{2{$past(step_dir[i])}}, {2{$past(step_pulse[i])}}}))
         else $error("pulse and direction lines wrong");
      a_strobe_route: assert property ($past(rst_b) |->
         serial_encoder_strobe_out[i] == (!index_oe_b[i] && $past(serial_encoder_strobe[i])))
         else $error("index line strobe wrong");
   end
endmodule
bind axis_feedback_pin_routing axis_feedback_pin_routing_checker #(.CHANNELS(CHANNELS)) u_chk (.*);

// File: feedback_drive_model.sv
`timescale 1ns/100ps
// Connector-side drive; yields every line the block turns into an output
module feedback_drive_model #(
   parameter int unsigned CH = 2
) (
   // Drive levels and block outputs
   input wire logic [CH-1:0] a_drv,
   input wire logic [CH-1:0] b_drv,
   input wire logic [CH-1:0] idx_drv,
   input wire logic [CH-1:0] enc_a_out,
   input wire logic [CH-1:0] enc_a_oe_b,
   input wire logic [CH-1:0] serial_encoder_strobe_out,
   input wire logic [CH-1:0] index_oe_b,
   // Resolved connector lines
   output logic [CH-1:0] enc_a_in,
   output logic [CH-1:0] enc_b_in,
   output logic [CH-1:0] enc_index_in
);
   // A line the block drives reads back its level, not ours
   assign enc_a_in = (enc_a_oe_b & a_drv) | (~enc_a_oe_b & enc_a_out);
   assign enc_b_in = b_drv;
   assign enc_index_in = (index_oe_b & idx_drv) | (~index_oe_b & serial_encoder_strobe_out);
endmodule

// File: test_axis_feedback_pin_routing.sv
`timescale 1ns/100ps
module test_axis_feedback_pin_routing;
   localparam int unsigned CH = 2;
   logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, legacy_board, piggyback_board, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, st;
   logic [15:0] pat;
   logic [7:0] flag_tuvw_out, fexp, v;
   logic [5:0] ctrl;
   logic [3:0] pstrb;
   logic [2:0] first_hw_channel, hw;
   logic [1:0] amp_enable_route_strap, amp_fault_route_strap, index_share_strap, amp_enable;
   logic [1:0] amp_fault_conn, step_pulse, step_dir, serial_encoder_strobe, a_drv, b_drv, idx_drv;
   logic [1:0] enc_a_core, enc_b_core, enc_index_core, amp_fault_state, enc_a_in, enc_b_in, sen;
   logic [1:0] enc_index_in, enc_a_out, enc_a_oe_b, flag_tuvw_oe_b, index_oe_b, flt;
   logic [1:0] serial_encoder_strobe_out;
   int fails, cmp_count, cycles;
   axis_feedback_pin_routing #(.CHANNELS(CH)) u_dut (.*);
   feedback_drive_model #(.CH(CH)) u_drive (.*);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Whole run needs about 6200 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic ck(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      // pready high ends this wait, else the bench timeout
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] strap_word();
      return {19'h0, legacy_board, 2'h0, index_share_strap, 2'h0, amp_fault_route_strap,
         2'h0, amp_enable_route_strap};
   endfunction
   task automatic check_routes();
      sen = ctrl[5:4] & ({2{legacy_board}} | ~index_share_strap);
      flt = amp_fault_route_strap;
      for (int i = 0; i < CH; i++)
         fexp[4*i+:4] = ctrl[i] ? {{2{step_dir[i]}}, {2{step_pulse[i]}}} : 4'h0;
      ck("a_oe", 32'(enc_a_oe_b), {30'h0, ~amp_enable_route_strap});
      ck("a_out", 32'(enc_a_out), 32'(amp_enable_route_strap & amp_enable));
      ck("a_core", 32'(enc_a_core), 32'(~amp_enable_route_strap & a_drv));
      ck("b_core", 32'(enc_b_core), 32'(~flt & b_drv));
      ck("fault", 32'(amp_fault_state), 32'((flt & b_drv) | (~flt & amp_fault_conn)));
      ck("tuvw_oe", 32'(flag_tuvw_oe_b), {30'h0, ~ctrl[1:0]});
      ck("tuvw", 32'(flag_tuvw_out), 32'(fexp));
      ck("idx_oe", 32'(index_oe_b), {30'h0, ~sen});
      ck("strobe", 32'(serial_encoder_strobe_out), 32'(sen & serial_encoder_strobe));
      ck("idx_core", 32'(enc_index_core), 32'(~sen & idx_drv));
      ck("hw_chan", 32'(first_hw_channel), 32'(hw));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_b, psel, penable, pwrite, legacy_board, piggyback_board} = '0;
      {paddr, pwdata, ctrl, fails, cmp_count, cycles} = '0;
      pstrb = 4'hF;
      hw = pin_routing_pkg::HW_CHAN_BASE;
      {amp_enable_route_strap, amp_fault_route_strap, index_share_strap} = '0;
      {amp_enable, amp_fault_conn, step_pulse, step_dir} = '0;
      {serial_encoder_strobe, a_drv, b_drv, idx_drv} = '0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b0, pin_routing_pkg::CTRL_OFFSET, 32'h0);
      ck("ctrl_reset", rd, pin_routing_pkg::CTRL_RESET);
      check_routes();
      // 256 strap and control mixes, each with both data polarities
      for (int k = 0; k < 256; k++) begin
         v = 8'(k);
         amp_enable_route_strap <= v[1:0];
         amp_fault_route_strap <= v[2:1];
         index_share_strap <= v[3:2];
         legacy_board <= v[4];
         piggyback_board <= v[0] ^ v[2];
         hw = (v[0] ^ v[2]) ? pin_routing_pkg::HW_CHAN_PIGGY : pin_routing_pkg::HW_CHAN_BASE;
         ctrl = {v[6:5], 2'h0, v[7], v[3]};
         apb(1'b1, pin_routing_pkg::CTRL_OFFSET, {26'h0, ctrl});
         apb(1'b0, pin_routing_pkg::CTRL_OFFSET, 32'h0);
         ck("ctrl", rd, {26'h0, ctrl});
         apb(1'b0, pin_routing_pkg::STRAP_OFFSET, 32'h0);
         ck("strap", rd, strap_word());
         apb(1'b0, pin_routing_pkg::BOARD_OFFSET, 32'h0);
         ck("board_err", 32'(err), 32'h0);
         ck("board", rd, {29'h0, hw});
         for (int p = 0; p < 2; p++) begin
            pat = {v, v} ^ 16'hA5C3 ^ {16{p[0]}};
            {amp_enable, amp_fault_conn, step_pulse, step_dir} <= pat[15:8];
            {serial_encoder_strobe, a_drv, b_drv, idx_drv} <= pat[7:0];
            repeat (2) @(posedge mclk);
            check_routes();
         end
         apb(1'b0, pin_routing_pkg::STATUS_OFFSET, 32'h0);
         st = {18'h0, sen, 2'h0, ctrl[1:0], 2'h0, amp_enable_route_strap, 4'h0};
         st[1:0] = (flt & b_drv) | (~flt & amp_fault_conn);
         ck("status", rd, st);
      end
      // Reset in mid-run must drop the host's enables
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      ck("tuvw_in_reset", 32'(flag_tuvw_oe_b), 32'h3);
      rst_b <= 1'b1;
      ctrl = '0;
      apb(1'b0, pin_routing_pkg::CTRL_OFFSET, 32'h0);
      ck("ctrl_again", rd, 32'h0);
      check_routes();
      apb(1'b1, pin_routing_pkg::STRAP_OFFSET, 32'hFFFF_FFFF);
      apb(1'b0, pin_routing_pkg::STRAP_OFFSET, 32'h0);
      ck("strap_ro", rd, strap_word());
      apb(1'b0, 12'h010, 32'h0);
      ck("unmapped_err", 32'(err), 32'h1);
      ck("unmapped_data", rd, 32'h0);
      // Lane 0 strobe low: the control write must be ignored
      pstrb <= 4'hE;
      apb(1'b1, pin_routing_pkg::CTRL_OFFSET, 32'h0000_0033);
      pstrb <= 4'hF;
      apb(1'b0, pin_routing_pkg::CTRL_OFFSET, 32'h0);
      ck("ctrl_lane0", rd, 32'h0);
      results();
   end
endmodule
